// File: core/gpm_ports.sv
`timescale 1ns/1ns
// Notes on behaviour
// - five port blocks A to E of eight pin slots each, of which up to 36 are usable pins.
// - a data write reaches the pin driver one edge later, so a pin can change every cycle.
// - each pin has a maskable interrupt on rising, falling, both edges, high or low level.
// - reads and writes of port data touch only pins selected by the address mask.
// - per-pin pull-up, pull-down, 2/4/8 mA drive, open drain, digital enable; slew only at 8 mA.
// - a cleared digital enable cuts the digital input path, leaving the analog path to software.
// - an alternate function drives a pin only with select and digital enable set and a code.
// - every pin is configured by its own bits with no grouping.
// - non-exception pins reset to tri-stated plain I/O with all settings zero.
// - the asynchronous reset returns every pin, exceptions included, to its default.
// - port A bits 5:0 and port B bits 3:2 reset to select 1, enable 1, no pulls, code 0x1.
// - port C bits 3:0 reset to select 1, enable 1, pull-up 1, code 0x3.
// - every direction bit resets to input.
module gpm_ports #(
	parameter int NP = gpm_pkg::NUM_PORTS,
	parameter int PW = gpm_pkg::PORT_W
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// data access: port select, address mask, write data
	input wire logic [2:0] acc_port,
	input wire logic [7:0] acc_mask,
	input wire logic acc_wr,
	input wire logic [7:0] acc_wdata,
	output logic [7:0] acc_rdata,
	// per-pin configuration writes, one pin at a time
	input wire logic cfg_wr,
	input wire logic [5:0] cfg_pin,
	input wire logic cfg_dir,
	input wire logic cfg_alt,
	input wire logic cfg_den,
	input wire logic cfg_pup,
	input wire logic cfg_pdn,
	input wire logic cfg_odr,
	input wire logic cfg_slew,
	input wire logic [1:0] cfg_drive,
	input wire logic [3:0] cfg_mux,
	input wire logic cfg_ie,
	input wire logic [2:0] cfg_sense,
	// interrupt clear by pin, and pending status
	input wire logic irq_clr,
	input wire logic [5:0] irq_clr_pin,
	output logic [NP*PW-1:0] irq_status,
	output logic irq_req,
	// pads
	input wire logic [NP*PW-1:0] pad_in,
	output logic [NP*PW-1:0] pad_out,
	output logic [NP*PW-1:0] pad_oe,
	output logic [NP*PW-1:0] pad_pup,
	output logic [NP*PW-1:0] pad_pdn,
	output logic [2*NP*PW-1:0] pad_drive,
	output logic [NP*PW-1:0] pad_slew,
	// peripheral side: code 1 and code 3 functions
	input wire logic [NP*PW-1:0] per1_out,
	input wire logic [NP*PW-1:0] per1_oe,
	input wire logic [NP*PW-1:0] per3_out,
	input wire logic [NP*PW-1:0] per3_oe,
	output logic [NP*PW-1:0] per_in
);
	// five ports of eight pin slots
	localparam int N = NP * PW;

	// ----------------------------------------------------------------
	// per-pin state
	// ----------------------------------------------------------------
	logic [N-1:0] data_r, data_nxt, dir_r, dir_nxt, alt_r, alt_nxt, den_r, den_nxt;
	logic [N-1:0] pup_r, pup_nxt, pdn_r, pdn_nxt, odr_r, odr_nxt, slew_r, slew_nxt;
	logic [N-1:0] ie_r, ie_nxt, ist_r, ist_nxt, prev_r, prev_nxt;
	logic [1:0] drv_r [N], drv_nxt [N];
	logic [3:0] mux_r [N], mux_nxt [N];
	logic [2:0] sns_r [N], sns_nxt [N];
	logic [N-1:0] din, hit;

	// ----------------------------------------------------------------
	// per-pin logic
	// ----------------------------------------------------------------
	// each pin has its own slice
	for (genvar i = 0; i < N; i++)
	begin : g_pin
		localparam int P = i / PW;
		localparam int B = i % PW;
		localparam logic [7:0] AM = (P == gpm_pkg::PORT_A) ? gpm_pkg::RST_A_ALT :
			(P == gpm_pkg::PORT_B) ? gpm_pkg::RST_B_ALT :
			(P == gpm_pkg::PORT_C) ? gpm_pkg::RST_C_ALT : gpm_pkg::RST_NONE;
		localparam logic [7:0] UM = (P == gpm_pkg::PORT_C) ? gpm_pkg::RST_C_PUP :
			gpm_pkg::RST_NONE;
		localparam logic R_ALT = AM[B];
		localparam logic R_PUP = UM[B];
		localparam logic [3:0] R_MUX = !R_ALT ? gpm_pkg::MUX_NONE :
			(P == gpm_pkg::PORT_C) ? gpm_pkg::MUX_DEBUG : gpm_pkg::MUX_PERIPH;
		logic sel, use1, use3, pin_o, pin_e;

		assign sel = cfg_wr && (cfg_pin == 6'(i));
		// digital input path gated by the digital enable
		assign din[i] = pad_in[i] & den_r[i];
		assign per_in[i] = din[i];

		// one peripheral only, and only with a nonzero code
		assign use1 = alt_r[i] && den_r[i] && (mux_r[i] == gpm_pkg::MUX_PERIPH);
		assign use3 = alt_r[i] && den_r[i] && (mux_r[i] == gpm_pkg::MUX_DEBUG);

		always_comb
		begin
			if (use1)
			begin
				pin_o = per1_out[i];
				pin_e = per1_oe[i];
			end
			else if (use3)
			begin
				pin_o = per3_out[i];
				pin_e = per3_oe[i];
			end
			else
			begin
				pin_o = data_r[i];
				pin_e = dir_r[i] && !(alt_r[i] && den_r[i] && mux_r[i] != gpm_pkg::MUX_NONE);
			end
		end

		assign pad_out[i] = odr_r[i] ? 1'b0 : pin_o;
		assign pad_oe[i] = odr_r[i] ? (pin_e && !pin_o) : pin_e;
		assign pad_pup[i] = pup_r[i];
		assign pad_pdn[i] = pdn_r[i];
		assign pad_drive[2*i+1:2*i] = drv_r[i];
		// slew applies only at 8 mA
		assign pad_slew[i] = slew_r[i] && (drv_r[i] == gpm_pkg::GPM_DRV_8MA);

		// detection per sense code, masked by the enable
		always_comb
		begin
			case (sns_r[i])
				gpm_pkg::GPM_IRQ_RISE: hit[i] = din[i] && !prev_r[i];
				gpm_pkg::GPM_IRQ_FALL: hit[i] = !din[i] && prev_r[i];
				gpm_pkg::GPM_IRQ_BOTH: hit[i] = din[i] != prev_r[i];
				gpm_pkg::GPM_IRQ_HIGH: hit[i] = din[i];
				gpm_pkg::GPM_IRQ_LOW: hit[i] = !din[i];
				default: hit[i] = 1'b0;
			endcase
		end

		always_comb
		begin
			// masked write, on the pin one edge later
			data_nxt[i] = (acc_wr && acc_port == 3'(P) && acc_mask[B]) ? acc_wdata[B] : data_r[i];
			dir_nxt[i] = sel ? cfg_dir : dir_r[i];
			alt_nxt[i] = sel ? cfg_alt : alt_r[i];
			den_nxt[i] = sel ? cfg_den : den_r[i];
			pup_nxt[i] = sel ? cfg_pup : pup_r[i];
			pdn_nxt[i] = sel ? cfg_pdn : pdn_r[i];
			odr_nxt[i] = sel ? cfg_odr : odr_r[i];
			slew_nxt[i] = sel ? cfg_slew : slew_r[i];
			drv_nxt[i] = sel ? cfg_drive : drv_r[i];
			mux_nxt[i] = sel ? cfg_mux : mux_r[i];
			sns_nxt[i] = sel ? cfg_sense : sns_r[i];
			ie_nxt[i] = sel ? cfg_ie : ie_r[i];
			prev_nxt[i] = din[i];
			// set wins over clear
			ist_nxt[i] = (ie_r[i] && hit[i]) ||
				(ist_r[i] && !(irq_clr && irq_clr_pin == 6'(i)));
		end

		always_ff @(posedge core_clk or negedge reset_n)
		begin
			if (!reset_n)
			begin
				data_r[i] <= 1'b0;
				dir_r[i] <= 1'b0;
				alt_r[i] <= R_ALT;
				den_r[i] <= R_ALT;
				pup_r[i] <= R_PUP;
				pdn_r[i] <= 1'b0;
				odr_r[i] <= 1'b0;
				slew_r[i] <= 1'b0;
				drv_r[i] <= gpm_pkg::GPM_DRV_2MA;
				mux_r[i] <= R_MUX;
				sns_r[i] <= gpm_pkg::GPM_IRQ_RISE;
				ie_r[i] <= 1'b0;
				ist_r[i] <= 1'b0;
				prev_r[i] <= 1'b0;
			end
			else
			begin
				data_r[i] <= data_nxt[i];
				dir_r[i] <= dir_nxt[i];
				alt_r[i] <= alt_nxt[i];
				den_r[i] <= den_nxt[i];
				pup_r[i] <= pup_nxt[i];
				pdn_r[i] <= pdn_nxt[i];
				odr_r[i] <= odr_nxt[i];
				slew_r[i] <= slew_nxt[i];
				drv_r[i] <= drv_nxt[i];
				mux_r[i] <= mux_nxt[i];
				sns_r[i] <= sns_nxt[i];
				ie_r[i] <= ie_nxt[i];
				ist_r[i] <= ist_nxt[i];
				prev_r[i] <= prev_nxt[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// read and interrupt outputs
	// ----------------------------------------------------------------
	logic [7:0] rd_nxt, rd_r;
	always_comb
	begin
		rd_nxt = 8'h00;
		for (int b = 0; b < PW; b++)
			if (int'(acc_port) < NP)
				rd_nxt[b] = acc_mask[b] &
					(dir_r[int'(acc_port)*PW+b] ? data_r[int'(acc_port)*PW+b] :
					din[int'(acc_port)*PW+b]);
	end
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			rd_r <= 8'h00;
		else
			rd_r <= rd_nxt;
	end
	assign acc_rdata = rd_r;
	assign irq_status = ist_r;
	assign irq_req = |ist_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	// write visible next cycle on a plain output pin of port D
	toggle_path_a: assert property ((acc_wr && acc_port == 3'h3 && acc_mask[0]
		&& dir_r[24] && !alt_r[24] && !odr_r[24] && !(cfg_wr && cfg_pin == 6'h18))
		|=> pad_out[24] == $past(acc_wdata[0]))
		else $error("toggle write not seen on pin");
	read_mask_a: assert property (!acc_mask[0] |=> acc_rdata[0] == 1'b0)
		else $error("masked read bit not zero");
	irq_mask_a: assert property (!ie_r[32] && !ist_r[32] |=> !ist_r[32])
		else $error("masked source set status");
	digital_gate_a: assert property (!den_r[0] |-> per_in[0] == 1'b0)
		else $error("digital path open while disabled");
	// code zero keeps plain I/O drive
	zero_code_a: assert property (mux_r[0] == gpm_pkg::MUX_NONE && !odr_r[0]
		|-> pad_oe[0] == dir_r[0])
		else $error("code zero changed pin control");
	slew_drive_a: assert property (pad_slew[35] |-> drv_r[35] == gpm_pkg::GPM_DRV_8MA)
		else $error("slew without 8 mA drive");
	alt_gate_a: assert property (!den_r[0] && !dir_r[0] |-> !pad_oe[0])
		else $error("pin driven while disabled");
	// every direction bit is input right after reset
	reset_dir_a: assert property ($rose(reset_n) |-> dir_r == '0)
		else $error("direction not input after reset");
	rise_set_a: assert property (ie_r[32] && sns_r[32] == gpm_pkg::GPM_IRQ_RISE
		&& din[32] && !prev_r[32] |=> ist_r[32] ##0 irq_req)
		else $error("rising edge lost");

	toggle_c: cover property (acc_wr ##2 acc_wr);
	irq_c: cover property ($rose(irq_req));
	alt_c: cover property (alt_r[0] && den_r[0] && mux_r[0] == gpm_pkg::MUX_DEBUG);
	read_c: cover property (acc_rdata != 8'h00);
endmodule : gpm_ports

// File: common/gpm_pkg.sv
package gpm_pkg;
	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int NUM_PORTS = 5;
	localparam int PORT_W = 8;
	localparam int NUM_PINS = NUM_PORTS * PORT_W;
	localparam int MUX_W = 4;
	localparam int PORT_A = 0;
	localparam int PORT_B = 1;
	localparam int PORT_C = 2;
	// ----------------------------------------------------------------
	// mux codes
	// ----------------------------------------------------------------
	localparam logic [3:0] MUX_NONE = 4'h0;
	localparam logic [3:0] MUX_PERIPH = 4'h1;
	localparam logic [3:0] MUX_DEBUG = 4'h3;
	// ----------------------------------------------------------------
	// exception pins, one bit per pin within a port
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_A_ALT = 8'h3f;
	localparam logic [7:0] RST_B_ALT = 8'h0c;
	localparam logic [7:0] RST_C_ALT = 8'h0f;
	localparam logic [7:0] RST_C_PUP = 8'h0f;
	localparam logic [7:0] RST_NONE = 8'h00;
	// ----------------------------------------------------------------
	// interrupt sense and drive codes
	// ----------------------------------------------------------------
	typedef enum logic [2:0]
	{
		GPM_IRQ_RISE = 3'h0,
		GPM_IRQ_FALL = 3'h1,
		GPM_IRQ_BOTH = 3'h2,
		GPM_IRQ_HIGH = 3'h3,
		GPM_IRQ_LOW = 3'h4
	} gpm_sense_t;
	typedef enum logic [1:0]
	{
		GPM_DRV_2MA = 2'h0,
		GPM_DRV_4MA = 2'h1,
		GPM_DRV_8MA = 2'h2
	} gpm_drive_t;
endpackage : gpm_pkg

// File: testbench/gpm_pad_model.sv
`timescale 1ns/1ns
module gpm_pad_model (
	// pads of the block
	input wire logic [gpm_pkg::NUM_PINS-1:0] pad_out,
	input wire logic [gpm_pkg::NUM_PINS-1:0] pad_oe,
	// level of the outside source
	input wire logic [gpm_pkg::NUM_PINS-1:0] ext_val,
	output logic [gpm_pkg::NUM_PINS-1:0] pad_in
);
	// ----------------------------------------------------------------
	// pad resolution
	// ----------------------------------------------------------------
	// block drive wins
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_val);
endmodule : gpm_pad_model

// File: testbench/tb_gpio_ports_with_function_mux.sv
`timescale 1ns/1ns
module tb_gpio_ports_with_function_mux;
	// ----------------------------------------------------------------
	// bench signals and helpers
	// ----------------------------------------------------------------
	localparam int N = gpm_pkg::NUM_PINS;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic acc_wr = 1'b0, cfg_wr = 1'b0, irq_clr = 1'b0, irq_req;
	logic [2:0] acc_port = 3'h0;
	logic [7:0] acc_mask = 8'h00, acc_wdata = 8'h00, acc_rdata;
	logic [5:0] cfg_pin = 6'h00, irq_clr_pin = 6'h20;
	// dir alt den pup pdn odr slew ie, mux, drive, sense
	logic [16:0] cfg_v = 17'h00000;
	logic [N-1:0] irq_status, pad_in, pad_out, pad_oe, pad_pup, pad_pdn, pad_slew, per_in;
	logic [2*N-1:0] pad_drive;
	logic [N-1:0] per1_out, per1_oe, per3_out, per3_oe, ext_val;
	logic [31:0] seed = 32'h0000000d;
	logic [7:0] data_q [8] = '{default: 8'h00};
	logic [6:0] irq_tab [7] = '{7'h0b, 7'h1d, 7'h2d, 7'h3b, 7'h4d, 7'h0c, 7'h02};
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;
	always #4 core_clk = ~core_clk;
	gpm_ports i_dut (.core_clk, .reset_n, .acc_port, .acc_mask, .acc_wr, .acc_wdata, .acc_rdata,
		.cfg_wr, .cfg_pin, .cfg_dir(cfg_v[16]), .cfg_alt(cfg_v[15]), .cfg_den(cfg_v[14]),
		.cfg_pup(cfg_v[13]), .cfg_pdn(cfg_v[12]), .cfg_odr(cfg_v[11]), .cfg_slew(cfg_v[10]),
		.cfg_ie(cfg_v[9]), .cfg_mux(cfg_v[8:5]), .cfg_drive(cfg_v[4:3]), .cfg_sense(cfg_v[2:0]),
		.irq_clr, .irq_clr_pin, .irq_status, .irq_req, .pad_in, .pad_out, .pad_oe, .pad_pup,
		.pad_pdn, .pad_drive, .pad_slew, .per1_out, .per1_oe, .per3_out, .per3_oe, .per_in);
	gpm_pad_model i_pads (.pad_out, .pad_oe, .ext_val, .pad_in);
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	// expected peripheral routing of the pins that come up in a function
	function automatic logic [N-1:0] alt_exp(input logic [N-1:0] e1, input logic [N-1:0] e3);
		return (e1 & 40'h0000000c3f) | (e3 & 40'h00000f0000);
	endfunction : alt_exp
	task automatic chk(input logic [N-1:0] got, input logic [N-1:0] exp, input string what);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic cfg(input int pin, input logic [16:0] v);
		@(negedge core_clk);
		cfg_wr = 1'b1;
		cfg_pin = pin[5:0];
		cfg_v = v;
		@(negedge core_clk);
		cfg_wr = 1'b0;
	endtask : cfg
	task automatic check_defaults();
		chk(pad_oe, alt_exp(per1_oe, per3_oe), "reset oe");
		chk(pad_out, alt_exp(per1_out, per3_out), "reset mux");
		chk(N'({|pad_drive, |pad_slew, |irq_status, irq_req}), '0, "reset misc");
		chk(pad_pup, 40'h00000f0000, "pull up");
		chk(pad_pdn, '0, "pull down");
		chk(per_in, pad_in & 40'h00000f0c3f, "input path");
	endtask : check_defaults
	task automatic complete_run();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 2000)
		begin
			failures++;
			$display("[FAIL] %0t timeout", $time);
			complete_run();
		end
	end
	initial
	begin
		logic [31:0] w;
		logic [6:0] t;
		logic [4:0] g;
		per1_out = N'({rnd(), rnd()});
		per1_oe = N'({rnd(), rnd()});
		per3_out = N'({rnd(), rnd()});
		per3_oe = N'({rnd(), rnd()});
		ext_val = N'({rnd(), rnd()});
		repeat (4) @(negedge core_clk);
		reset_n = 1'b1;
		@(negedge core_clk);
		check_defaults();
		$display("test reset defaults done");
		for (int p = 24; p < 32; p++)
			cfg(p, 17'h14000);
		for (int i = 0; i < 41; i++)
		begin
			w = rnd();
			@(negedge core_clk);
			chk(N'(pad_out[31:24]), N'(data_q[3]), "data out");
			acc_wr = (i < 40);
			acc_port = (i % 4 == 0 && i < 40) ? w[2:0] : 3'h3;
			acc_mask = w[15:8];
			acc_wdata = w[23:16];
			if (i < 40)
				data_q[acc_port] = (data_q[acc_port] & ~acc_mask) | (acc_wdata & acc_mask);
		end
		@(negedge core_clk);
		chk(N'(acc_rdata), N'(data_q[3] & w[15:8]), "read");
		$display("test data access done");
		ext_val[0] = 1'b1;
		per1_oe[0] = 1'b1;
		per3_oe[0] = 1'b1;
		per1_out[0] = ~per3_out[0];
		cfg(0, 17'h1c000);
		chk(N'({pad_oe[1:0], pad_out[0]}), N'({per1_oe[1], 1'b1, data_q[0][0]}), "io");
		cfg(0, 17'h0c060);
		chk(N'({pad_oe[0], pad_out[0]}), N'({1'b1, per3_out[0]}), "code three");
		cfg(0, 17'h08020);
		chk(N'({pad_oe[0], per_in[0]}), N'(2'b00), "no enable");
		$display("test function mux done");
		for (int d = 0; d < 3; d++)
		begin
			w = rnd();
			cfg(35, {3'b001, w[1:0], 3'b010, 4'h0, d[1:0], 3'h0});
			g = {pad_drive[71:70], pad_slew[35], pad_pup[35], pad_pdn[35]};
			chk(N'(g), N'({d[1:0], d == 2, w[1:0]}), "pad");
		end
		$display("test pad setup done");
		for (int i = 0; i < 7; i++)
		begin
			t = irq_tab[i];
			ext_val[32] = t[2];
			cfg(32, {8'h20 | {7'h00, t[3]}, 6'h00, t[6:4]});
			repeat (3) @(negedge core_clk);
			irq_clr = 1'b1;
			@(negedge core_clk);
			irq_clr = 1'b0;
			ext_val[32] = t[1];
			repeat (3) @(negedge core_clk);
			chk(N'({irq_status[32], irq_req}), N'({2{t[0]}}), "irq");
		end
		$display("test interrupts done");
		reset_n = 1'b0;
		repeat (2) @(negedge core_clk);
		reset_n = 1'b1;
		@(negedge core_clk);
		check_defaults();
		$display("test second reset done");
		complete_run();
	end
endmodule : tb_gpio_ports_with_function_mux
